// ### verilog/vip_defines.svh
// constants for the vectored interrupt priority controller
`ifndef VIP_DEFINES_SVH
`define VIP_DEFINES_SVH
// ==========================================================
// register byte addresses
`define VIP_ADDR_STATUS_WORD 8'h42
`define VIP_ADDR_CORE_CTRL 8'h44
`define VIP_ADDR_DIS_COUNT 8'h52
`define VIP_ADDR_ICON2 8'h60
`define VIP_ADDR_PEND_VEC 8'h62
`define VIP_ADDR_IRQ_STAT 8'h64
`define VIP_ADDR_IRQ_MASK 8'h66
`define VIP_ADDR_FLAG_BASE 8'h80
`define VIP_ADDR_EN_BASE 8'h90
`define VIP_ADDR_PRI_BASE 8'hA0
// ==========================================================
// sizes and fields
`define VIP_NUM_SRC 32
`define VIP_NUM_TRAP 8
`define VIP_NUM_VEC 126
`define VIP_IPL_LO 5
`define VIP_ALT_BIT 15
`define VIP_TOP_BIT 3
// program memory layout, word addresses
`define VIP_PRIMARY_BASE 24'h000004
`define VIP_ALT_BASE 24'h000082
// entry and return counter loads; both take three cycles from the take or retfie sample, whichever source
`define VIP_ENTRY_CYCLES 4'h4
`define VIP_RETURN_CYCLES 4'h3
`endif

// ### verilog/vip_pkg.sv
// types shared by the interrupt controller files
package vip_pkg;
  // ==========================================================
  // sequencer states, gray coded along entry path
  typedef enum logic [2:0] {
    VIP_IDLE = 3'h0,
    VIP_FETCH = 3'h1,
    VIP_WAIT = 3'h3,
    VIP_RUN = 3'h2,
    VIP_RET = 3'h6
  } vip_state_e;
  typedef logic [6:0] vip_vec_t;
  typedef logic [3:0] vip_lvl_t;
endpackage : vip_pkg

// ### verilog/vip_arbiter.sv
// level based priority arbiter over traps and maskable sources
`timescale 1ns/1ps
`include "vip_defines.svh"
module vip_arbiter (
  input wire logic [`VIP_NUM_TRAP-1:0] trap_req,
  input wire logic [`VIP_NUM_SRC-1:0] src_live,
  input wire logic [`VIP_NUM_SRC*3-1:0] src_level,
  output logic win_valid,
  output vip_pkg::vip_vec_t win_vec,
  output vip_pkg::vip_lvl_t win_lvl
);
  import vip_pkg::*;
  // ==========================================================
  // selection: highest level first, ties to lower vector
  always_comb begin
    win_valid = 1'b0;
    win_vec = 7'h00;
    win_lvl = 4'h0;
    for (int i = `VIP_NUM_SRC - 1; i >= 0; i--) begin
      if (src_live[i] && ({1'b0, src_level[i*3 +: 3]} >= win_lvl || !win_valid)) begin
        win_valid = 1'b1;
        win_vec = 7'(i + `VIP_NUM_TRAP);
        win_lvl = {1'b0, src_level[i*3 +: 3]};
      end
    end
    // traps outrank all levels and cannot be masked
    for (int t = `VIP_NUM_TRAP - 1; t >= 0; t--) begin
      if (trap_req[t]) begin
        win_valid = 1'b1;
        win_vec = 7'(t);
        // trap 0 sits at level 15, trap 7 at level 8, always above any source
        win_lvl = 4'(15 - t);
      end
    end
  end
endmodule : vip_arbiter

// ### verilog/vip_ctrl.sv
// interrupt controller top: registers, priority, vector fetch
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "vip_defines.svh"
// How it works
// - many request lines become one cpu request
// - 126 entries, eight traps never maskable
// - each source gets software priority level
// - primary table starts at word 000004h
// - entry gives 24-bit handler branch address
// - ties go to lower vector number
// - same level uses fixed vector order
// - every source has its own vector
// - alternate select bit swaps fetch table
// - alternate table follows primary, same layout
// - fixed entry and return cycle counts
// - cpu level lives in status bits 7:5
// - top level bit read-only in core control
// - latch winning vector and new level
// - hardware sets flags, software clears, enables gate
module vip_ctrl (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [`VIP_NUM_SRC-1:0] src_event,
  input wire logic [`VIP_NUM_TRAP-1:0] trap_event,
  input wire logic cpu_take,
  input wire logic cpu_retfie,
  input wire logic [23:0] pmem_data,
  output logic cpu_irq,
  output logic [23:0] pmem_addr,
  output logic pmem_rd,
  output logic [23:0] branch_addr,
  output logic branch_go,
  output logic ret_done,
  output logic irq_out
);
  import vip_pkg::*;
  // ==========================================================
  // state record
  typedef struct packed {
    vip_state_e st;
    logic [3:0] cnt;
    logic [2:0] cpu_priority_level;
    logic top;
    logic [3:0] ipl_save;
    logic top_save;
    logic [13:0] discnt;
    logic alt_sel;
    logic [`VIP_NUM_SRC-1:0] flag;
    logic [`VIP_NUM_SRC-1:0] en;
    logic [`VIP_NUM_SRC*3-1:0] pri;
    logic [`VIP_NUM_TRAP-1:0] trap;
    vip_vec_t pend_vec;
    vip_lvl_t pend_lvl;
    logic [1:0] ev_stat;
    logic [1:0] ev_mask;
    logic [15:0] rdata;
    logic irq;
    logic [23:0] paddr;
    logic prd;
    logic [23:0] baddr;
    logic bgo;
    logic rdone;
    logic iout;
  } vip_regs_s;
  vip_regs_s s_q, s_d;
  logic win_valid;
  vip_vec_t win_vec;
  vip_lvl_t win_lvl;
  logic [`VIP_NUM_SRC-1:0] live;
  // word index inside the priority bank, five 3-bit levels per word
  function automatic logic [2:0] vip_bank(input logic [7:0] a);
    vip_bank = a[3:1];
  endfunction : vip_bank
  // priority words sit at the even addresses A0 up to AC, seven words for 32 sources
  function automatic logic vip_pri_hit(input logic [7:0] a);
    vip_pri_hit = (a[7:4] == 4'hA) && (a[3:1] != 3'h7);
  endfunction : vip_pri_hit
  assign live = s_q.flag & s_q.en;
  vip_arbiter u_arb (
    .trap_req(s_q.trap),
    .src_live(live),
    .src_level(s_q.pri),
    .win_valid(win_valid),
    .win_vec(win_vec),
    .win_lvl(win_lvl)
  );
  // ==========================================================
  // next state
  always_comb begin
    logic req;
    logic [15:0] rd;
    req = 1'b0;
    rd = 16'h0000;
    s_d = s_q;
    s_d.bgo = 1'b0;
    s_d.rdone = 1'b0;
    s_d.prd = 1'b0;
    req = win_valid && (win_lvl > {s_q.top, s_q.cpu_priority_level}) && (win_lvl[3] || s_q.discnt == 14'h0);
    if (s_q.discnt != 14'h0) begin
      s_d.discnt = s_q.discnt - 14'h1;
    end
    if (win_valid) begin
      s_d.pend_vec = win_vec;
      s_d.pend_lvl = win_lvl;
    end
    s_d.irq = req && s_q.st == VIP_IDLE;
    // software writes; clear of flags done before hardware set
    if (reg_wr) begin
      unique case (reg_addr)
        `VIP_ADDR_STATUS_WORD: s_d.cpu_priority_level = reg_wdata[`VIP_IPL_LO +: 3];
        `VIP_ADDR_DIS_COUNT: s_d.discnt = reg_wdata[13:0];
        `VIP_ADDR_ICON2: s_d.alt_sel = reg_wdata[`VIP_ALT_BIT];
        `VIP_ADDR_IRQ_MASK: s_d.ev_mask = reg_wdata[1:0];
        default: begin
          if (vip_pri_hit(reg_addr)) begin
            // source i lives in word i/5, slot i%5; the last word holds only two
            for (int i = 0; i < `VIP_NUM_SRC; i++) begin
              if (vip_bank(reg_addr) == 3'(i / 5)) begin
                s_d.pri[i*3 +: 3] = reg_wdata[(i % 5) * 3 +: 3];
              end
            end
          end else if (reg_addr[7:2] == 6'h20) begin
            s_d.flag[reg_addr[1]*16 +: 16] = reg_wdata;
          end else if (reg_addr[7:2] == 6'h24) begin
            s_d.en[reg_addr[1]*16 +: 16] = reg_wdata;
          end
        end
      endcase
    end
    s_d.flag = s_d.flag | src_event;
    // sequencer: fixed latency whichever source
    unique case (s_q.st)
      VIP_IDLE: begin
        if (cpu_take && req) begin
          s_d.st = VIP_FETCH;
          s_d.cnt = `VIP_ENTRY_CYCLES;
          s_d.ipl_save = {s_q.top, s_q.cpu_priority_level};
          s_d.cpu_priority_level = win_lvl[2:0];
          // top bit set only by hardware
          s_d.top = win_lvl[3];
          if (win_vec < 7'(`VIP_NUM_TRAP)) s_d.trap[win_vec[2:0]] = 1'b0;
          s_d.paddr = (s_q.alt_sel ? `VIP_ALT_BASE : `VIP_PRIMARY_BASE) + {17'h0, win_vec};
          s_d.prd = 1'b1;
        end else if (cpu_retfie) begin
          s_d.st = VIP_RET;
          s_d.cnt = `VIP_RETURN_CYCLES;
        end
      end
      VIP_FETCH: begin
        s_d.baddr = pmem_data;
        s_d.st = VIP_WAIT;
        s_d.cnt = s_q.cnt - 4'h1;
      end
      VIP_WAIT: begin
        s_d.cnt = s_q.cnt - 4'h1;
        if (s_q.cnt == 4'h2) begin
          s_d.st = VIP_RUN;
          s_d.bgo = 1'b1;
          s_d.ev_stat[0] = 1'b1;
        end
      end
      VIP_RUN: begin
        s_d.st = VIP_IDLE;
      end
      VIP_RET: begin
        s_d.cnt = s_q.cnt - 4'h1;
        if (s_q.cnt == 4'h1) begin
          s_d.st = VIP_IDLE;
          s_d.rdone = 1'b1;
          s_d.ev_stat[1] = 1'b1;
          s_d.cpu_priority_level = s_q.ipl_save[2:0];
          s_d.top = s_q.ipl_save[3];
        end
      end
      default: s_d.st = VIP_IDLE;
    endcase
    // trap events land after the take clear, so a repeat in that cycle is kept
    s_d.trap = s_d.trap | trap_event;
    // register reads, data valid next cycle
    unique case (reg_addr)
      `VIP_ADDR_STATUS_WORD: rd = {8'h00, s_q.cpu_priority_level, 5'h00};
      `VIP_ADDR_CORE_CTRL: rd = {12'h000, s_q.top, 3'h0};
      `VIP_ADDR_DIS_COUNT: rd = {2'h0, s_q.discnt};
      `VIP_ADDR_ICON2: rd = {s_q.alt_sel, 15'h0000};
      `VIP_ADDR_PEND_VEC: rd = {4'h0, s_q.pend_lvl, 1'b0, s_q.pend_vec};
      `VIP_ADDR_IRQ_STAT: rd = {14'h0000, s_q.ev_stat};
      `VIP_ADDR_IRQ_MASK: rd = {14'h0000, s_q.ev_mask};
      default: begin
        if (vip_pri_hit(reg_addr)) begin
          for (int i = 0; i < `VIP_NUM_SRC; i++) begin
            if (vip_bank(reg_addr) == 3'(i / 5)) rd[(i % 5) * 3 +: 3] = s_q.pri[i*3 +: 3];
          end
        end else if (reg_addr[7:2] == 6'h20) rd = s_q.flag[reg_addr[1]*16 +: 16];
        else if (reg_addr[7:2] == 6'h24) rd = s_q.en[reg_addr[1]*16 +: 16];
      end
    endcase
    s_d.rdata = reg_rd ? rd : 16'h0000;
    // read clears event status, but a new event in the same cycle stays
    if (reg_rd && reg_addr == `VIP_ADDR_IRQ_STAT) begin
      s_d.ev_stat = s_d.ev_stat & ~s_q.ev_stat;
      s_d.ev_stat = s_d.ev_stat | {s_d.rdone, s_d.bgo};
    end
    s_d.iout = |(s_d.ev_stat & s_d.ev_mask);
  end
  // ==========================================================
  // state register, synchronous reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign reg_rdata = s_q.rdata;
  assign cpu_irq = s_q.irq;
  assign pmem_addr = s_q.paddr;
  assign pmem_rd = s_q.prd;
  assign branch_addr = s_q.baddr;
  assign branch_go = s_q.bgo;
  assign ret_done = s_q.rdone;
  assign irq_out = s_q.iout;
  // ==========================================================
  // checks
  // branch follows fetch after fixed delay
  branch_after_fetch_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pmem_rd |-> ##3 branch_go) else $error("branch not on time");
  alt_table_addr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(pmem_rd) && $past(s_q.alt_sel) |-> pmem_addr >= `VIP_ALT_BASE)
    else $error("alternate base not used");
  level_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cpu_irq |-> $past(win_lvl) > $past({s_q.top, s_q.cpu_priority_level})) else $error("request below level");
  ret_latency_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_q.st == VIP_IDLE && cpu_retfie && !(cpu_take && cpu_irq) |-> ##4 ret_done)
    else $error("return latency wrong");
  flag_sticky_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    src_event[0] |=> s_q.flag[0]) else $error("event lost");
  // line rises only on an event or mask write
  irq_out_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(irq_out) |-> branch_go || ret_done || $past(reg_wr)) else $error("irq out wrong");
  trap_wins_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    |s_q.trap |-> win_lvl[3]) else $error("trap not top");
  top_ro_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && s_q.st == VIP_IDLE && !cpu_take |=> $stable(s_q.top)) else $error("top bit written");
  cov_entry_c: cover property (@(posedge ref_clk) branch_go);
  cov_alt_c: cover property (@(posedge ref_clk) pmem_rd && s_q.alt_sel);
  cov_ret_c: cover property (@(posedge ref_clk) ret_done);
  cov_trap_c: cover property (@(posedge ref_clk) s_q.top && branch_go);
  cov_hold_c: cover property (@(posedge ref_clk) s_q.discnt != 14'h0 && win_valid);
  // primary fetch stays inside primary table
  primary_addr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(pmem_rd) && !$past(s_q.alt_sel) |->
      pmem_addr >= `VIP_PRIMARY_BASE && pmem_addr < `VIP_ALT_BASE)
    else $error("primary base not used");
  pend_latch_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    win_valid |=> s_q.pend_vec == $past(win_vec)) else $error("pending vector not latched");
  status_wr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && reg_addr == `VIP_ADDR_STATUS_WORD && s_q.st == VIP_IDLE && !cpu_take |=>
      s_q.cpu_priority_level == $past(reg_wdata[7:5])) else $error("cpu level write lost");
endmodule : vip_ctrl

// ### sim/vip_cpu_model.sv
// cpu core and program memory stand-in facing the controller
`timescale 1ns/1ps
module vip_cpu_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic arm,
  input wire logic [3:0] lag,
  input wire logic cpu_irq,
  input wire logic pmem_rd,
  input wire logic [23:0] pmem_addr,
  output logic cpu_take,
  output logic [23:0] pmem_data
);
  // ==========
  // acceptance
  logic pend_q;
  logic [3:0] wait_q;
  // one request taken per arm, after lag cycles so slow cores are covered
  always_ff @(posedge ref_clk) begin
    if (!rst_n || pmem_rd) begin
      pend_q <= 1'b0;
      cpu_take <= 1'b0;
      wait_q <= 4'h0;
    end else if (arm) begin
      pend_q <= 1'b1;
    end else if (pend_q && cpu_irq) begin
      if (wait_q >= lag) begin
        cpu_take <= 1'b1;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
  // ==========
  // program memory
  logic [23:0] churn_q;
  logic [23:0] slot;
  // the alternate table, fetched on odd rounds, holds the same handlers as the primary
  assign slot = (pmem_addr >= 24'h000082) ? pmem_addr - 24'h00007E : pmem_addr;
  // word stands while the fetch strobe is high; churns otherwise so late samples show
  assign pmem_data = pmem_rd ? {slot[11:0], ~slot[11:0]} : churn_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      churn_q <= 24'h5A5A5A;
    end else begin
      churn_q <= ~churn_q;
    end
  end
endmodule : vip_cpu_model

// ### sim/tb_top.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
module tb_top;
  logic ref_clk, rst_n, reg_wr, reg_rd, cpu_take, cpu_retfie, arm;
  logic pmem_rd, cpu_irq, branch_go, ret_done, irq_out;
  logic [7:0] reg_addr, trap_event;
  logic [15:0] reg_wdata, reg_rdata, d, w;
  logic [31:0] src_event, ev, en;
  logic [23:0] pmem_data, pmem_addr, branch_addr, base;
  logic [3:0] lag;
  int n_mismatch, checks_done, n, r, bv, bl, t;
  int lv[32];
  vip_ctrl u_vip_ctrl (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .src_event, .trap_event, .cpu_take, .cpu_retfie, .pmem_data, .cpu_irq, .pmem_addr,
    .pmem_rd, .branch_addr, .branch_go, .ret_done, .irq_out);
  vip_cpu_model u_vip_cpu_model (.ref_clk, .rst_n, .arm, .lag, .cpu_irq, .pmem_rd,
    .pmem_addr, .cpu_take, .pmem_data);
  // ==========
  // helpers
  task chk(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task give_verdict;
    if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  task wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  // bounded wait on pmem_rd (0), branch_go (1) or ret_done (2)
  task await(input int k, output int c);
    c = 0;
    #1;
    while ((k == 0 ? pmem_rd : k == 1 ? branch_go : ret_done) !== 1'b1) begin
      @(posedge ref_clk);
      #1 c++;
      if (c > 40) begin
        n_mismatch++;
        give_verdict();
      end
    end
  endtask : await
  // full entry and return for expected vector v
  task enter(input int v);
    @(posedge ref_clk);
    arm <= 1'b1;
    lag <= 4'($urandom % 4);
    @(posedge ref_clk);
    arm <= 1'b0;
    await(0, n);
    chk(pmem_addr, base + 24'(v));
    await(1, n);
    chk(24'(n), 24'h3);
    chk(branch_addr, {12'(v + 4), ~12'(v + 4)});
    @(posedge ref_clk);
    cpu_retfie <= 1'b1;
    @(posedge ref_clk);
    cpu_retfie <= 1'b0;
    await(2, n);
    chk(24'(n), 24'h3);
  endtask : enter
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // ==========
  // main sequence
  initial begin
    {rst_n, reg_wr, reg_rd, cpu_retfie, arm, lag, reg_addr, reg_wdata} = '0;
    {src_event, trap_event} = '0;
    n_mismatch = 0;
    checks_done = 0;
    void'($urandom(32'h6edcdedf));
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(8'h42, d);
    chk(d, 24'h0);
    rd(8'h44, d);
    chk(d, 24'h0);
    rd(8'h10, d);
    chk(d, 24'h0);
    wr(8'h52, 16'h0000);
    wr(8'h44, 16'hFFFF);
    rd(8'h44, d);
    chk(d[3], 24'h0);
    wr(8'h42, 16'h00E0);
    rd(8'h42, d);
    chk(d[7:5], 24'h7);
    for (r = 0; r < 6; r++) begin
      foreach (lv[i]) lv[i] = $urandom % 8;
      lv[0] = 1 + $urandom % 7;
      for (int k = 0; k < 7; k++) begin
        w = 16'h0000;
        for (int j = 0; j < 5; j++) if (5 * k + j < 32) w[3 * j +: 3] = 3'(lv[5 * k + j]);
        wr(8'(8'hA0 + 2 * k), w);
      end
      en = $urandom | 32'h1;
      ev = $urandom | 32'h1;
      base = r[0] ? 24'h000082 : 24'h000004;
      wr(8'h90, en[15:0]);
      wr(8'h92, en[31:16]);
      wr(8'h60, {r[0], 15'h0000});
      wr(8'h66, (r == 1) ? 16'h0000 : 16'h0003);
      @(posedge ref_clk);
      src_event <= ev;
      @(posedge ref_clk);
      src_event <= '0;
      bv = 0;
      bl = 0;
      // strict compare keeps the lowest vector among equals
      for (int i = 0; i < 32; i++) if (ev[i] && en[i] && lv[i] > bl) begin
        bl = lv[i];
        bv = i + 8;
      end
      if (r == 0) begin
        repeat (3) @(posedge ref_clk);
        #1 chk(cpu_irq, 24'h0);
        wr(8'h42, 16'h0000);
      end else if (r == 2) begin
        // countdown holds maskable requests off until it runs out
        wr(8'h52, 16'h0010);
        repeat (2) @(posedge ref_clk);
        #1 chk(cpu_irq, 24'h0);
      end
      repeat (2) @(posedge ref_clk);
      rd(8'h62, d);
      chk(d, {12'h0, 4'(bl), 1'b0, 7'(bv)});
      enter(bv);
      repeat (2) @(posedge ref_clk);
      #1 chk(irq_out, (r != 1)); // masked round keeps the line low
      rd(8'h64, d);
      chk(d[1:0], 24'h3);
      repeat (2) @(posedge ref_clk);
      #1 chk(irq_out, 24'h0);
      wr(8'h80, 16'h0000);
      wr(8'h82, 16'h0000);
    end
    // trap beats every source even at cpu level 7
    t = $urandom % 8;
    wr(8'h42, 16'h00E0);
    @(posedge ref_clk);
    trap_event <= 8'(1 << t);
    src_event <= '1;
    @(posedge ref_clk);
    {trap_event, src_event} <= '0;
    repeat (2) @(posedge ref_clk);
    rd(8'h62, d);
    chk(d, {12'h0, 4'(15 - t), 1'b0, 7'(t)});
    enter(t);
    give_verdict();
  end
endmodule : tb_top
